// ===== pcss_pkg.sv
// Purpose: shared constants and types of the pci core status and port select block
// Assumes: 32-bit axi4-lite register bus, one clock
// Notes: register offsets are byte addresses
package pcss_pkg;

    // bus widths
    localparam int DATA_W = 32;
    localparam int EXT_W = 4;
    localparam int ADDR_W = 5;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 5'h10;

    // control / status field positions; mask bits follow the command/status word
    localparam int CTRL_QUAD_POS = 0;
    localparam int POS_MDPE = 8;
    localparam int POS_STA = 11;
    localparam int POS_RTA = 12;
    localparam int POS_RMA = 13;
    localparam int POS_SSE = 14;
    localparam int POS_DPE = 15;
    localparam int STAT_WIDE_POS = 0;
    localparam int STAT_ERR_POS = 1;
    localparam int STAT_PHASE64_POS = 2;
    localparam int STAT_SHIFT_POS = 3;

    // reset values: all masks pass, dual-port mode
    localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000f900;
    localparam logic [DATA_W-1:0] CTRL_WMASK = 32'h0000f901;

    // interrupt bits
    localparam int IRQ_W = 2;
    localparam int IRQ_ERR_POS = 0;
    localparam int IRQ_WIDE_POS = 1;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // status shifter
    localparam int NUM_STAT = 6;
    localparam int IDX_W = 3;
    localparam logic [IDX_W-1:0] LAST_IDX = 3'h5;

    // msb first is the serial order: bit 5, det_parity, leaves first
    typedef struct packed {
        logic det_parity;
        logic sig_system;
        logic rcv_master_abort;
        logic rcv_target_abort;
        logic sig_target_abort;
        logic master_data_parity;
    } pcss_dev_status_t;

    typedef enum logic [1:0] {
        SH_OR = 2'b01,
        SH_SHIFT = 2'b10
    } pcss_shift_mode_t;

    typedef struct packed {
        logic [EXT_W-1:0] ext;
        logic [DATA_W-1:0] data;
    } pcss_rx_bus_t;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } pcss_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } pcss_axil_rsp_t;

endpackage

// ===== pcss_status_shifter.sv
// Purpose: drives the error-status output as masked or, or as a serial bit stream
// Assumes: shift enable input is synchronous to aclk
// Notes: output is registered, so it follows its inputs by one edge
`timescale 1ns/100ps
`default_nettype none
module pcss_status_shifter (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // status and control
    input wire pcss_pkg::pcss_dev_status_t dev_status,
    input wire logic [pcss_pkg::NUM_STAT-1:0] mask,
    input wire logic shift_enable_n,
    // result
    output logic err_status,
    output logic shifting
);
    typedef struct packed {
        pcss_pkg::pcss_shift_mode_t mode;
        logic [pcss_pkg::IDX_W-1:0] idx;
        logic out;
    } pcss_shift_state_t;

    pcss_shift_state_t st;
    pcss_shift_state_t next_st;
    logic [pcss_pkg::NUM_STAT-1:0] vec;
    logic masked_or;
    logic cur_bit;

    assign vec = dev_status;
    assign masked_or = |(vec & mask);
    assign cur_bit = vec[3'(pcss_pkg::LAST_IDX - st.idx)];

    always_comb begin
        next_st = st;
        case (st.mode)
            pcss_pkg::SH_OR: begin
                if (!shift_enable_n) begin
                    next_st.mode = pcss_pkg::SH_SHIFT;
                end
            end
            pcss_pkg::SH_SHIFT: begin
                if (shift_enable_n) begin
                    next_st.mode = pcss_pkg::SH_OR;
                end
            end
            default: begin
                next_st.mode = pcss_pkg::SH_OR;
            end
        endcase
        if (shift_enable_n) begin
            next_st.idx = '0;
            next_st.out = masked_or;
        end else begin
            next_st.out = cur_bit;
            if (st.idx != pcss_pkg::LAST_IDX) begin
                next_st.idx = st.idx + 3'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '{mode: pcss_pkg::SH_OR, idx: '0, out: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign err_status = st.out;
    assign shifting = (st.mode == pcss_pkg::SH_SHIFT);

    or_mode_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
        shift_enable_n |=> err_status == $past(masked_or)) else $error("or mode output wrong");
    shift_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        shift_enable_n |=> st.idx == 3'h0) else $error("shift index not cleared");
    shift_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!shift_enable_n && st.idx != pcss_pkg::LAST_IDX) |=> st.idx == $past(st.idx) + 3'h1)
        else $error("shift index did not advance");
    shift_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !shift_enable_n |=> err_status == $past(cur_bit)) else $error("serial bit wrong");
    first_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ($fell(shift_enable_n) ##0 $past(shift_enable_n)) |=> err_status == $past(vec[5]))
        else $error("serial stream did not start with first bit");
    shift_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!shift_enable_n && st.idx == pcss_pkg::LAST_IDX) |=> st.idx == pcss_pkg::LAST_IDX)
        else $error("last bit not held");
    full_shift_c: cover property (@(posedge aclk) disable iff (!aresetn)
        $fell(shift_enable_n) ##0 (!shift_enable_n) [*7]);
endmodule
`default_nettype wire

// ===== pcss_wide_strap.sv
// Purpose: catches the 64-bit agent strap at the release of pci reset
// Assumes: pci reset and req64 inputs are synchronous to aclk
// Notes: flag clears while pci reset is low
`timescale 1ns/100ps
`default_nettype none
module pcss_wide_strap (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pci strap pins
    input wire logic pci_rst_n,
    input wire logic req64_n,
    // result
    output logic wide_bus_indication
);
    typedef struct packed {
        logic rst_prev;
        logic wide;
    } pcss_strap_state_t;

    pcss_strap_state_t st;
    pcss_strap_state_t next_st;
    logic rst_rise;

    assign rst_rise = pci_rst_n && !st.rst_prev;

    always_comb begin
        next_st = st;
        next_st.rst_prev = pci_rst_n;
        if (!pci_rst_n) begin
            next_st.wide = 1'b0;
        end else if (rst_rise) begin
            next_st.wide = !req64_n;
        end
    end

    // strap is taken by the clocked process, never loaded by the reset itself
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wide_bus_indication = st.wide;

    strap_catch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rst_rise |=> wide_bus_indication == !$past(req64_n)) else $error("strap not caught");
    strap_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (pci_rst_n && !rst_rise) |=> $stable(wide_bus_indication)) else $error("strap changed");
    wide_set_c: cover property (@(posedge aclk) disable iff (!aresetn)
        rst_rise && !req64_n);
endmodule
`default_nettype wire

// ===== pcss_top.sv
// Purpose: status reporting, wide-bus strap and receive data steering for an embedded pci core
// Assumes: single 200 mhz aclk, synchronous active-low reset, axi4-lite register access
// Notes: one write and one read in flight; answers come one edge after both halves arrive
//
// Functional notes
// - shift enable high: output is the or of the six masked status bits.
// - shift enable low: status bits leave one per rising clock edge.
// - shift counter held cleared while shift enable is high.
// - output sourced from the six listed device status error bits.
// - wide-bus indication set when req64 was low at pci reset rise.
// - wide-bus indication says nothing about any one transaction's width; here phase_64bit simply follows it.
// - with wide-bus indication, fifo transfers may use 64-bit data phases.
// - dual-port: select 0 gives master read data, 1 gives target data.
// - or-mode masks sit at command/status bits 8 and 11 to 15.
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module pcss_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire pcss_pkg::pcss_axil_req_t axil_req,
    output pcss_pkg::pcss_axil_rsp_t axil_rsp,
    // core status
    input wire pcss_pkg::pcss_dev_status_t dev_status,
    input wire logic shift_enable_n,
    output logic err_status,
    // pci strap
    input wire logic pci_rst_n,
    input wire logic req64_n,
    output logic wide_bus_indication,
    output logic phase_64bit,
    // receive data steering
    input wire logic rx_data_select,
    input wire pcss_pkg::pcss_rx_bus_t master_rd,
    input wire pcss_pkg::pcss_rx_bus_t target_wd,
    output pcss_pkg::pcss_rx_bus_t rx_bus,
    // interrupt
    output logic irq
);
    typedef struct packed {
        logic aw_held;
        logic [pcss_pkg::ADDR_W-1:0] awaddr;
        logic w_held;
        logic [pcss_pkg::DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [pcss_pkg::DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic [pcss_pkg::DATA_W-1:0] ctrl;
        logic [pcss_pkg::IRQ_W-1:0] irq_en;
        logic [pcss_pkg::IRQ_W-1:0] irq_st;
        logic err_prev;
        logic wide_prev;
        pcss_pkg::pcss_rx_bus_t rx;
    } pcss_top_state_t;

    pcss_top_state_t st;
    pcss_top_state_t next_st;
    logic [pcss_pkg::NUM_STAT-1:0] mask_vec;
    logic shifting;
    logic quad_mode;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic do_write;
    logic [pcss_pkg::ADDR_W-1:0] wr_addr;
    logic [pcss_pkg::DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic [pcss_pkg::DATA_W-1:0] status_word;
    logic [pcss_pkg::IRQ_W-1:0] irq_set;

    assign mask_vec = {st.ctrl[pcss_pkg::POS_DPE], st.ctrl[pcss_pkg::POS_SSE],
                       st.ctrl[pcss_pkg::POS_RMA], st.ctrl[pcss_pkg::POS_RTA],
                       st.ctrl[pcss_pkg::POS_STA], st.ctrl[pcss_pkg::POS_MDPE]};
    assign quad_mode = st.ctrl[pcss_pkg::CTRL_QUAD_POS];

    pcss_status_shifter u_shifter (
        .aclk(aclk),
        .aresetn(aresetn),
        .dev_status(dev_status),
        .mask(mask_vec),
        .shift_enable_n(shift_enable_n),
        .err_status(err_status),
        .shifting(shifting)
    );

    pcss_wide_strap u_strap (
        .aclk(aclk),
        .aresetn(aresetn),
        .pci_rst_n(pci_rst_n),
        .req64_n(req64_n),
        .wide_bus_indication(wide_bus_indication)
    );

    // agent flag only: transaction widths are negotiated on the pci bus
    // 64-bit data phases follow the strap
    assign phase_64bit = wide_bus_indication;

    // byte-lane merge of a write into a stored word
    function automatic logic [pcss_pkg::DATA_W-1:0] merge(
        input logic [pcss_pkg::DATA_W-1:0] old_v,
        input logic [pcss_pkg::DATA_W-1:0] new_v,
        input logic [3:0] strb);
        logic [pcss_pkg::DATA_W-1:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic mapped(input logic [pcss_pkg::ADDR_W-1:0] a);
        logic [pcss_pkg::ADDR_W-1:0] w;
        w = {a[pcss_pkg::ADDR_W-1:2], 2'b00};
        return (w == pcss_pkg::OFF_CTRL) || (w == pcss_pkg::OFF_STATUS)
            || (w == pcss_pkg::OFF_IRQ_STATUS) || (w == pcss_pkg::OFF_IRQ_CLEAR)
            || (w == pcss_pkg::OFF_IRQ_ENABLE);
    endfunction

    // live status: raw error bits at their command/status positions
    always_comb begin
        status_word = '0;
        status_word[pcss_pkg::STAT_WIDE_POS] = wide_bus_indication;
        status_word[pcss_pkg::STAT_ERR_POS] = err_status;
        status_word[pcss_pkg::STAT_PHASE64_POS] = phase_64bit;
        status_word[pcss_pkg::STAT_SHIFT_POS] = shifting;
        status_word[pcss_pkg::POS_DPE] = dev_status.det_parity;
        status_word[pcss_pkg::POS_SSE] = dev_status.sig_system;
        status_word[pcss_pkg::POS_RMA] = dev_status.rcv_master_abort;
        status_word[pcss_pkg::POS_RTA] = dev_status.rcv_target_abort;
        status_word[pcss_pkg::POS_STA] = dev_status.sig_target_abort;
        status_word[pcss_pkg::POS_MDPE] = dev_status.master_data_parity;
    end

    assign axil_rsp.awready = !st.aw_held && !st.bvalid;
    assign axil_rsp.wready = !st.w_held && !st.bvalid;
    assign axil_rsp.bvalid = st.bvalid;
    assign axil_rsp.bresp = st.bresp;
    assign axil_rsp.arready = !st.rvalid;
    assign axil_rsp.rvalid = st.rvalid;
    assign axil_rsp.rdata = st.rdata;
    assign axil_rsp.rresp = st.rresp;

    assign aw_fire = axil_req.awvalid && axil_rsp.awready;
    assign w_fire = axil_req.wvalid && axil_rsp.wready;
    assign ar_fire = axil_req.arvalid && axil_rsp.arready;
    assign do_write = (st.aw_held || aw_fire) && (st.w_held || w_fire);
    assign wr_addr = st.aw_held ? st.awaddr : axil_req.awaddr;
    assign wr_data = st.w_held ? st.wdata : axil_req.wdata;
    assign wr_strb = st.w_held ? st.wstrb : axil_req.wstrb;

    // events: masked or rising in or mode, strap newly set
    always_comb begin
        irq_set = '0;
        irq_set[pcss_pkg::IRQ_ERR_POS] = shift_enable_n && !shifting && err_status
            && !st.err_prev;
        irq_set[pcss_pkg::IRQ_WIDE_POS] = wide_bus_indication && !st.wide_prev;
    end

    always_comb begin
        next_st = st;
        next_st.err_prev = err_status && !shifting;
        next_st.wide_prev = wide_bus_indication;
        next_st.rx = (quad_mode || rx_data_select) ? target_wd : master_rd;

        if (st.bvalid && axil_req.bready) begin
            next_st.bvalid = 1'b0;
        end
        if (aw_fire && !do_write) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr = axil_req.awaddr;
        end
        if (w_fire && !do_write) begin
            next_st.w_held = 1'b1;
            next_st.wdata = axil_req.wdata;
            next_st.wstrb = axil_req.wstrb;
        end

        next_st.irq_st = st.irq_st;
        if (do_write) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = mapped(wr_addr) ? pcss_pkg::RESP_OKAY : pcss_pkg::RESP_SLVERR;
            case ({wr_addr[pcss_pkg::ADDR_W-1:2], 2'b00})
                pcss_pkg::OFF_CTRL: begin
                    next_st.ctrl = merge(st.ctrl, wr_data, wr_strb) & pcss_pkg::CTRL_WMASK;
                end
                pcss_pkg::OFF_IRQ_CLEAR: begin
                    if (wr_strb[0]) begin
                        next_st.irq_st = st.irq_st & ~wr_data[pcss_pkg::IRQ_W-1:0];
                    end
                end
                pcss_pkg::OFF_IRQ_ENABLE: begin
                    if (wr_strb[0]) begin
                        next_st.irq_en = wr_data[pcss_pkg::IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // a new event outranks a clear in the same cycle
        next_st.irq_st = next_st.irq_st | irq_set;

        if (st.rvalid && axil_req.rready) begin
            next_st.rvalid = 1'b0;
        end
        if (ar_fire) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = pcss_pkg::RESP_OKAY;
            next_st.rdata = '0;
            case ({axil_req.araddr[pcss_pkg::ADDR_W-1:2], 2'b00})
                pcss_pkg::OFF_CTRL: begin
                    next_st.rdata = st.ctrl;
                end
                pcss_pkg::OFF_STATUS: begin
                    next_st.rdata = status_word;
                end
                pcss_pkg::OFF_IRQ_STATUS: begin
                    next_st.rdata[pcss_pkg::IRQ_W-1:0] = st.irq_st;
                end
                pcss_pkg::OFF_IRQ_CLEAR: begin
                    next_st.rdata = '0;
                end
                pcss_pkg::OFF_IRQ_ENABLE: begin
                    next_st.rdata[pcss_pkg::IRQ_W-1:0] = st.irq_en;
                end
                default: begin
                    next_st.rresp = pcss_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.ctrl <= pcss_pkg::CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign rx_bus = st.rx;
    assign irq = |(st.irq_st & st.irq_en);

    // steering: the shared bus shows the selected source one edge later
    rx_master_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!quad_mode && !rx_data_select) |=> rx_bus == $past(master_rd))
        else $error("master read data not selected");

    rx_target_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (quad_mode || rx_data_select) |=> rx_bus == $past(target_wd))
        else $error("target data not selected");

    phase_wide_a: assert property (@(posedge aclk) disable iff (!aresetn)
        phase_64bit == wide_bus_indication) else $error("phase width differs from strap");

    mask_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (shift_enable_n && !st.ctrl[pcss_pkg::POS_DPE] && !st.ctrl[pcss_pkg::POS_SSE]
         && !st.ctrl[pcss_pkg::POS_RMA] && !st.ctrl[pcss_pkg::POS_RTA]
         && !st.ctrl[pcss_pkg::POS_STA] && !st.ctrl[pcss_pkg::POS_MDPE])
        |=> !err_status) else $error("masked bits reached the output");

    // events: a set must land, a clear without a fresh event must empty the bit
    sticky_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_set[pcss_pkg::IRQ_ERR_POS] |=> st.irq_st[pcss_pkg::IRQ_ERR_POS])
        else $error("error event lost");

    wide_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wide_bus_indication && !st.wide_prev)
        |=> st.irq_st[pcss_pkg::IRQ_WIDE_POS])
        else $error("wide bus event lost");

    irq_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_write && {wr_addr[pcss_pkg::ADDR_W-1:2], 2'b00} == pcss_pkg::OFF_IRQ_CLEAR
         && wr_strb[0] && wr_data[pcss_pkg::IRQ_WIDE_POS] && !irq_set[pcss_pkg::IRQ_WIDE_POS])
        |=> !st.irq_st[pcss_pkg::IRQ_WIDE_POS])
        else $error("interrupt bit not cleared");

    irq_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_write && {wr_addr[pcss_pkg::ADDR_W-1:2], 2'b00} == pcss_pkg::OFF_IRQ_ENABLE
         && wr_strb[0])
        |=> st.irq_en == $past(wr_data[pcss_pkg::IRQ_W-1:0]))
        else $error("interrupt enable not written");

    // register bus: every request is answered; a refused one leaves state alone
    write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> axil_rsp.bvalid) else $error("write not answered");

    write_slverr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_write && !mapped(wr_addr))
        |=> (axil_rsp.bresp == pcss_pkg::RESP_SLVERR && $stable(st.ctrl)))
        else $error("unmapped write not refused");

    read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_fire
        |=> axil_rsp.rvalid)
        else $error("read not answered");

    read_slverr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_fire && !mapped(axil_req.araddr))
        |=> (axil_rsp.rresp == pcss_pkg::RESP_SLVERR && axil_rsp.rdata == '0))
        else $error("unmapped read not refused");

    // the status word is live, so it shows the strap as it stood when read
    status_wide_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_fire && {axil_req.araddr[pcss_pkg::ADDR_W-1:2], 2'b00} == pcss_pkg::OFF_STATUS)
        |=> axil_rsp.rdata[pcss_pkg::STAT_WIDE_POS] == $past(wide_bus_indication))
        else $error("status word lost the strap");

    irq_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));

    dual_target_c: cover property (@(posedge aclk) disable iff (!aresetn)
        !quad_mode && rx_data_select ##1 !rx_data_select);

    quad_mode_c: cover property (@(posedge aclk) disable iff (!aresetn)
        quad_mode && !rx_data_select);
endmodule
`default_nettype wire

// ===== pcss_dummy_end.sv
// Purpose: none
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== pcss_fabric_model.sv
// Purpose: fabric-side source of master read data, target data and the select
// Assumes: everything on aclk, synchronous active-low reset
// Notes: both buses change every cycle, so a stale or wrong select shows up
`timescale 1ns/100ps
`default_nettype none
module pcss_fabric_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // select request from the test
    input wire logic sel_req,
    // towards the block
    output logic rx_data_select,
    output pcss_pkg::pcss_rx_bus_t master_rd,
    output pcss_pkg::pcss_rx_bus_t target_wd
);
    logic [31:0] cnt;
    always_ff @(posedge aclk) begin
        cnt <= aresetn ? cnt + 32'h1 : 32'h0;
        rx_data_select <= sel_req;
        master_rd <= {4'h5, cnt};
        target_wd <= {4'ha, ~cnt};
    end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Purpose: self-checking bench for the status, strap and steering block
// Assumes: axi4-lite answers come when they come; bench waits under a bound
// Notes: bus signals change only by non-blocking assignment after a rising edge
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic aclk, aresetn, shift_enable_n, pci_rst_n, req64_n, sel_req, rx_sel;
    logic err_status, wide, phase, irq;
    pcss_pkg::pcss_axil_req_t req;
    pcss_pkg::pcss_axil_rsp_t rsp;
    pcss_pkg::pcss_dev_status_t dev;
    pcss_pkg::pcss_rx_bus_t m_rd, t_wd, rx_bus;
    int fails, checked;
    int pos[6] = '{8, 11, 12, 13, 14, 15};
    logic [5:0] pat = 6'b101001;

    pcss_top i_dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
        .dev_status(dev), .shift_enable_n(shift_enable_n), .err_status(err_status),
        .pci_rst_n(pci_rst_n), .req64_n(req64_n), .wide_bus_indication(wide),
        .phase_64bit(phase), .rx_data_select(rx_sel), .master_rd(m_rd),
        .target_wd(t_wd), .rx_bus(rx_bus), .irq(irq));
    pcss_fabric_model i_fab (.aclk(aclk), .aresetn(aresetn), .sel_req(sel_req),
        .rx_data_select(rx_sel), .master_rd(m_rd), .target_wd(t_wd));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task wrap_up;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // handshakes are judged at the falling edge, acted on at the next rise
    task wr(input logic [4:0] a, input logic [31:0] d);
        bit aw, w, b;
        logic [1:0] br;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        b = 0;
        br = 2'h3;
        while (!b) begin
            @(negedge aclk);
            aw = req.awvalid && rsp.awready;
            w = req.wvalid && rsp.wready;
            b = rsp.bvalid;
            br = rsp.bresp;
            @(posedge aclk);
            if (aw) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
            if (b) req.bready <= 1'b0;
        end
        chk("bresp", (a > 5'h10) ? 2'h2 : 2'h0, br);
    endtask

    task rchk(input string nm, input logic [4:0] a, input logic [31:0] exp,
              input logic [1:0] er);
        logic [31:0] dd;
        logic [1:0] rr;
        bit ar, v;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        v = 0;
        while (!v) begin
            @(negedge aclk);
            ar = req.arvalid && rsp.arready;
            v = rsp.rvalid;
            dd = rsp.rdata;
            rr = rsp.rresp;
            @(posedge aclk);
            if (ar) req.arvalid <= 1'b0;
            if (v) req.rready <= 1'b0;
        end
        chk(nm, exp, dd);
        chk({nm, "_resp"}, er, rr);
    endtask

    task orchk(input logic exp);
        repeat (2) @(posedge aclk);
        #1;
        chk("or_out", exp, err_status);
    endtask

    task shift_run(input int n);
        @(posedge aclk);
        shift_enable_n <= 1'b0;
        for (int k = 0; k < n; k++) begin
            @(posedge aclk);
            #1;
            chk("serial", pat[5 - (k > 5 ? 5 : k)], err_status);
        end
    endtask

    task rx_chk(input logic tgt);
        logic [35:0] ex;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        ex = tgt ? t_wd : m_rd;
        @(posedge aclk);
        #1;
        chk("rx_bus", ex, rx_bus);
    endtask

    initial begin
        repeat (4000) @(posedge aclk);
        fails++;
        wrap_up;
    end

    initial begin
        aresetn = 1'b0;
        req = '0;
        dev = '0;
        shift_enable_n = 1'b1;
        pci_rst_n = 1'b0;
        req64_n = 1'b0;
        sel_req = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("ctrl", 5'h00, 32'h0000f900, 2'h0);
        rchk("irq_en", 5'h10, 32'h0, 2'h0);
        rchk("unmapped", 5'h14, 32'h0, 2'h2);
        wr(5'h14, 32'h0);
        rchk("ctrl_kept", 5'h00, 32'h0000f900, 2'h0);
        @(posedge aclk);
        #1;
        chk("wide_pre", 0, wide);
        @(posedge aclk);
        pci_rst_n <= 1'b1;
        @(posedge aclk);
        #1;
        chk("wide", 1, wide);
        chk("phase64", 1, phase);
        rchk("irq_st", 5'h08, 32'h2, 2'h0);
        rchk("status", 5'h04, 32'h5, 2'h0);
        chk("irq_off", 0, irq);
        wr(5'h10, 32'h2);
        #1;
        chk("irq_on", 1, irq);
        wr(5'h0c, 32'h2);
        #1;
        chk("irq_clr", 0, irq);
        @(posedge aclk);
        pci_rst_n <= 1'b0;
        req64_n <= 1'b1;
        repeat (2) @(posedge aclk);
        #1;
        chk("wide_rst", 0, wide);
        @(posedge aclk);
        pci_rst_n <= 1'b1;
        repeat (2) @(posedge aclk);
        #1;
        chk("wide_32", 0, wide);
        for (int i = 0; i < 6; i++) begin
            @(posedge aclk);
            dev <= 6'h1 << i;
            orchk(1'b1);
            wr(5'h00, 32'h0000f900 & ~(32'h1 << pos[i]));
            orchk(1'b0);
            wr(5'h00, 32'h0000f900);
        end
        wr(5'h00, 32'h0);
        orchk(1'b0);
        wr(5'h00, 32'h0000f900);
        rchk("irq_err", 5'h08, 32'h1, 2'h0);
        wr(5'h10, 32'h1);
        #1;
        chk("irq_err_on", 1, irq);
        @(posedge aclk);
        dev <= pat;
        shift_run(8);
        @(posedge aclk);
        shift_enable_n <= 1'b1;
        @(posedge aclk);
        #1;
        chk("or_back", 1, err_status);
        shift_run(2);
        @(posedge aclk);
        sel_req <= 1'b0;
        rx_chk(1'b0);
        @(posedge aclk);
        sel_req <= 1'b1;
        rx_chk(1'b1);
        @(posedge aclk);
        sel_req <= 1'b0;
        wr(5'h00, 32'h0000f901);
        rx_chk(1'b1);
        wrap_up;
    end
endmodule
`default_nettype wire
